// ### hw/msd_pkg.sv
package msd_pkg;
  // Address widths
  localparam int PA_W = 24;
  localparam int PC_W = 23;
  localparam int DA_W = 16;
  localparam int WA_W = 15;
  localparam int NEAR_W = 13;
  localparam int PG_CFG_BIT = 7;
  localparam int PSV_BIT = 15;
  // Program space map
  localparam logic [22:0] PC_RESET = 23'h000000;
  localparam logic [22:0] PC_STEP = 23'h000002;
  localparam logic [23:0] VECTOR_END = 24'h000200;
  localparam logic [23:0] IVT_BASE = 24'h000004;
  localparam logic [23:0] IVT_END = 24'h0000FF;
  localparam logic [23:0] AIVT_BASE = 24'h000100;
  localparam logic [23:0] AIVT_END = 24'h0001FF;
  localparam logic [23:0] USER_MAX = 24'h7FFFFF;
  // Data space map
  localparam logic [15:0] SFR_END = 16'h07FF;
  localparam logic [15:0] NEAR_END = 16'h1FFF;
  localparam logic [15:0] DATA_END = 16'h3FFF;
  localparam logic [15:0] XY_BOUNDARY = 16'h0C00;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  // Byte lane strobes
  localparam logic [1:0] BE_NONE = 2'h0;
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_WORD = 2'h3;
  typedef enum logic [1:0] {AM_NEAR, AM_DIRECT, AM_INDIRECT} msd_amode_type;
  typedef enum logic [1:0] {ZN_NONE, ZN_SFR, ZN_RAM} msd_zone_type;
endpackage

// ### hw/msd_agu_if.sv
interface msd_agu_if;
  logic [15:0] ptr;
  logic        byte_op;
  logic        dec;
  logic        wr;
  logic        mod_en;
  logic [15:0] mod_start;
  logic [15:0] mod_end;
  logic        brev_en;
  logic [15:0] brev_mod;
  logic [15:0] ea;
  logic [15:0] ptr_next;
  modport agu (input ptr, byte_op, dec, wr, mod_en, mod_start, mod_end,
               brev_en, brev_mod, output ea, ptr_next);
  modport core (output ptr, byte_op, dec, wr, mod_en, mod_start, mod_end,
                brev_en, brev_mod, input ea, ptr_next);
endinterface

// ### hw/msd_agu.sv
module msd_agu #(
  parameter logic BREV_OK = 1'b0
) (
  msd_agu_if.agu bus
);
  import msd_pkg::*;

  // Reverse all bits of a pointer
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  logic [15:0] step;
  logic [15:0] lin;
  logic [15:0] brv;

  // Post-modify: address used is the pointer before update
  assign bus.ea = bus.ptr;
  assign step = bus.byte_op ? BYTE_STEP : WORD_STEP;
  assign brv = rev16(rev16(bus.ptr) + rev16(bus.brev_mod));

  // Linear step with optional modulo wrap
  always_comb begin
    lin = bus.dec ? bus.ptr - step : bus.ptr + step;
    if (bus.mod_en && !bus.dec && bus.ptr + step > bus.mod_end) begin
      lin = bus.mod_start;
    end else if (bus.mod_en && bus.dec && bus.ptr < bus.mod_start + step)
    begin
      lin = bus.mod_end + BYTE_STEP - step;
    end
  end

  // Bit reversal only on an X-space write generator
  assign bus.ptr_next = (BREV_OK && bus.brev_en && bus.wr) ? brv : lin;
endmodule

// ### hw/msd_decoder.sv
// Function
// - Program address is 24 bits, PC 23.
// - User program access limited below 0x800000.
// - Program word: even lower, odd upper, top empty.
// - PC word-aligned, steps two either way.
// - Reset starts at zero; vectors below 0x200.
// - Two vector tables 0x004-0x0FF, 0x100-0x1FF.
// - 16-bit byte EA; top bit selects window.
// - 16 KB memory; reads elsewhere return zero.
// - Low byte even address, high byte odd.
// - Post-modify steps one for byte, two word.
// - Byte read picks lane by bit 0.
// - Shared word decode, separate byte strobes.
// - Odd word access raises address error.
// - Misaligned read completes; write is suppressed.
// - Byte load writes register low byte only.
// - 0x0000-0x07FF registers; unused read zero.
// - Near region reached by 13-bit field.
// - Whole space by 16-bit field or pointer.
// - X and Y fetched together for MAC.
// - X has separate read and write buses.
// - Modulo both spaces; bit-reverse X writes.
// - All writes combined space; fixed boundary.
module msd_decoder (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  pc_step_i,
  input  wire logic                  pc_dir_dn_i,
  input  wire logic                  pc_load_i,
  input  wire logic [22:0]           pc_target_i,
  input  wire logic                  tbl_op_i,
  input  wire logic                  psv_fetch_i,
  input  wire logic [7:0]            table_page_register_i,
  input  wire logic [7:0]            psv_page_i,
  input  wire logic [15:0]           tbl_offset_i,
  input  wire logic [23:0]           prog_word_i,
  input  wire logic                  acc_valid_i,
  input  wire logic                  acc_write_i,
  input  wire logic                  acc_byte_i,
  input  wire msd_pkg::msd_amode_type amode_i,
  input  wire logic [15:0]           direct_addr_i,
  input  wire logic [15:0]           x_ptr_i,
  input  wire logic                  x_dec_i,
  input  wire logic                  mod_en_i,
  input  wire logic [15:0]           mod_start_i,
  input  wire logic [15:0]           mod_end_i,
  input  wire logic                  brev_en_i,
  input  wire logic [15:0]           brev_mod_i,
  input  wire logic [15:0]           wdata_i,
  input  wire logic                  dst_wreg_i,
  input  wire logic [15:0]           mem_rdata_i,
  input  wire logic [15:0]           sfr_rdata_i,
  input  wire logic                  sfr_ack_i,
  input  wire logic                  y_valid_i,
  input  wire logic [15:0]           y_ptr_i,
  input  wire logic                  y_dec_i,
  input  wire logic [15:0]           y_rdata_i,
  output logic [22:0]                pc_o,
  output logic [23:0]                prog_addr_o,
  output logic                       prog_fault_o,
  output logic                       vector_region_o,
  output logic                       ivt_hit_o,
  output logic                       aivt_hit_o,
  output logic [6:0]                 vector_index_o,
  output logic [15:0]                tbl_data_o,
  output logic [14:0]                x_word_addr_o,
  output logic                       x_rd_en_o,
  output logic [1:0]                 x_wr_be_o,
  output logic [15:0]                x_wdata_o,
  output logic                       addr_error_o,
  output logic                       psv_sel_o,
  output logic [15:0]                x_ptr_next_o,
  output logic [15:0]                x_rdata_o,
  output logic                       x_rvalid_o,
  output logic [1:0]                 wreg_be_o,
  output logic [14:0]                y_word_addr_o,
  output logic                       y_rd_en_o,
  output logic [15:0]                y_ptr_next_o,
  output logic [15:0]                y_rdata_o,
  output logic                       y_rvalid_o
);
  import msd_pkg::*;

  // Program group state
  logic [22:0] pc_reg, pc_next;
  logic [23:0] paddr_reg, paddr_next;
  logic        fault_reg, fault_next;
  logic        vec_reg, vec_next;
  logic        ivt_reg, ivt_next;
  logic        aivt_reg, aivt_next;
  logic [6:0]  vidx_reg, vidx_next;
  logic [15:0] tdata_reg, tdata_next;
  logic [23:0] paddr;

  // Access stage state
  logic [14:0]  xwa_reg, xwa_next;
  logic         xrd_reg, xrd_next;
  logic [1:0]   xbe_reg, xbe_next;
  logic [15:0]  xwd_reg, xwd_next;
  logic         err_reg, err_next;
  logic         psv_reg, psv_next;
  logic [15:0]  xptr_reg, xptr_next;
  logic         sbyte_reg, sbyte_next;
  logic         sea0_reg, sea0_next;
  msd_zone_type zone_reg, zone_next;
  logic         swreg_reg, swreg_next;
  logic [14:0]  ywa_reg, ywa_next;
  logic         yrd_reg, yrd_next;
  logic         yok_reg, yok_next;
  logic [15:0]  yptr_reg, yptr_next;

  // Read return state
  logic [15:0] xrdata_reg, xrdata_next;
  logic        xrv_reg, xrv_next;
  logic [1:0]  wbe_reg, wbe_next;
  logic [15:0] yrdata_reg, yrdata_next;
  logic        yrv_reg, yrv_next;

  logic [15:0]  x_ea;
  logic         misalign;
  msd_zone_type zone;
  logic [15:0]  xsel;

  msd_agu_if xi ();
  msd_agu_if yi ();

  // X generator serves reads and writes
  assign xi.ptr       = x_ptr_i;
  assign xi.byte_op   = acc_byte_i;
  assign xi.dec       = x_dec_i;
  assign xi.wr        = acc_write_i;
  assign xi.mod_en    = mod_en_i;
  assign xi.mod_start = mod_start_i;
  assign xi.mod_end   = mod_end_i;
  assign xi.brev_en   = brev_en_i;
  assign xi.brev_mod  = brev_mod_i;
  // Y generator reads words only, no bit reversal
  assign yi.ptr       = y_ptr_i;
  assign yi.byte_op   = 1'b0;
  assign yi.dec       = y_dec_i;
  assign yi.wr        = 1'b0;
  assign yi.mod_en    = mod_en_i;
  assign yi.mod_start = mod_start_i;
  assign yi.mod_end   = mod_end_i;
  assign yi.brev_en   = 1'b0;
  assign yi.brev_mod  = brev_mod_i;

  msd_agu #(.BREV_OK(1'b1)) u_x_agu (.bus(xi.agu));
  msd_agu #(.BREV_OK(1'b0)) u_y_agu (.bus(yi.agu));

  // Program address source and access checks
  always_comb begin
    if (tbl_op_i) begin
      paddr = {table_page_register_i, tbl_offset_i};
    end else if (psv_fetch_i) begin
      paddr = {psv_page_i, tbl_offset_i};
    end else begin
      paddr = {1'b0, pc_reg};
    end
    pc_next = pc_reg;
    if (pc_load_i) begin
      pc_next = {pc_target_i[22:1], 1'b0};
    end else if (pc_step_i) begin
      pc_next = pc_dir_dn_i ? pc_reg - PC_STEP : pc_reg + PC_STEP;
    end
    paddr_next = paddr;
    fault_next = (paddr > USER_MAX) &&
                 !(tbl_op_i && table_page_register_i[PG_CFG_BIT]);
    vec_next   = paddr < VECTOR_END;
    ivt_next   = paddr >= IVT_BASE && paddr <= IVT_END;
    aivt_next  = paddr >= AIVT_BASE && paddr <= AIVT_END;
    vidx_next  = paddr[7:1];
    // Odd address gives the upper word, top byte empty
    tdata_next = paddr_reg[0] ? {8'h00, prog_word_i[23:16]}
                              : prog_word_i[15:0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_reg    <= PC_RESET;
      paddr_reg <= 24'h000000;
      fault_reg <= 1'b0;
      vec_reg   <= 1'b1;
      ivt_reg   <= 1'b0;
      aivt_reg  <= 1'b0;
      vidx_reg  <= 7'h00;
      tdata_reg <= 16'h0000;
    end else if (ce_i) begin
      pc_reg    <= pc_next;
      paddr_reg <= paddr_next;
      fault_reg <= fault_next;
      vec_reg   <= vec_next;
      ivt_reg   <= ivt_next;
      aivt_reg  <= aivt_next;
      vidx_reg  <= vidx_next;
      tdata_reg <= tdata_next;
    end
  end

  // Effective address by mode
  always_comb begin
    unique case (amode_i)
      AM_NEAR:     x_ea = {3'b000, direct_addr_i[NEAR_W-1:0]};
      AM_DIRECT:   x_ea = direct_addr_i;
      AM_INDIRECT: x_ea = xi.ea;
      default:     x_ea = direct_addr_i;
    endcase
  end

  // Region decode and misalignment
  assign misalign = acc_valid_i && !acc_byte_i && x_ea[0];
  always_comb begin
    if (x_ea[PSV_BIT] || x_ea > DATA_END) begin
      zone = ZN_NONE;
    end else if (x_ea <= SFR_END) begin
      zone = ZN_SFR;
    end else begin
      zone = ZN_RAM;
    end
  end

  // Access stage next values
  always_comb begin
    xwa_next   = x_ea[15:1];
    xrd_next   = acc_valid_i && !acc_write_i;
    xbe_next   = BE_NONE;
    if (acc_valid_i && acc_write_i && zone != ZN_NONE && !misalign) begin
      if (!acc_byte_i) begin
        xbe_next = BE_WORD;
      end else begin
        xbe_next = x_ea[0] ? BE_HI : BE_LO;
      end
    end
    xwd_next   = acc_byte_i ? {wdata_i[7:0], wdata_i[7:0]} : wdata_i;
    err_next   = misalign ||
                 (y_valid_i && yi.ea[0]);
    psv_next   = acc_valid_i && x_ea[PSV_BIT];
    xptr_next  = (acc_valid_i && amode_i == AM_INDIRECT) ?
                 xi.ptr_next : xptr_reg;
    sbyte_next = acc_byte_i;
    sea0_next  = x_ea[0];
    zone_next  = zone;
    swreg_next = acc_valid_i && !acc_write_i && dst_wreg_i;
    ywa_next   = yi.ea[15:1];
    yrd_next   = y_valid_i;
    yok_next   = yi.ea >= XY_BOUNDARY && yi.ea <= DATA_END;
    yptr_next  = y_valid_i ? yi.ptr_next : yptr_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xwa_reg   <= 15'h0000;
      xrd_reg   <= 1'b0;
      xbe_reg   <= BE_NONE;
      xwd_reg   <= 16'h0000;
      err_reg   <= 1'b0;
      psv_reg   <= 1'b0;
      xptr_reg  <= 16'h0000;
      sbyte_reg <= 1'b0;
      sea0_reg  <= 1'b0;
      zone_reg  <= ZN_NONE;
      swreg_reg <= 1'b0;
      ywa_reg   <= 15'h0000;
      yrd_reg   <= 1'b0;
      yok_reg   <= 1'b0;
      yptr_reg  <= 16'h0000;
    end else if (ce_i) begin
      xwa_reg   <= xwa_next;
      xrd_reg   <= xrd_next;
      xbe_reg   <= xbe_next;
      xwd_reg   <= xwd_next;
      err_reg   <= err_next;
      psv_reg   <= psv_next;
      xptr_reg  <= xptr_next;
      sbyte_reg <= sbyte_next;
      sea0_reg  <= sea0_next;
      zone_reg  <= zone_next;
      swreg_reg <= swreg_next;
      ywa_reg   <= ywa_next;
      yrd_reg   <= yrd_next;
      yok_reg   <= yok_next;
      yptr_reg  <= yptr_next;
    end
  end

  // Source word, zero where nothing answers
  always_comb begin
    unique case (zone_reg)
      ZN_SFR:  xsel = sfr_ack_i ? sfr_rdata_i : 16'h0000;
      ZN_RAM:  xsel = mem_rdata_i;
      default: xsel = 16'h0000;
    endcase
  end

  // Read return next values
  always_comb begin
    xrdata_next = xsel;
    if (sbyte_reg) begin
      xrdata_next = sea0_reg ? {8'h00, xsel[15:8]}
                             : {8'h00, xsel[7:0]};
    end
    xrv_next    = xrd_reg;
    wbe_next    = BE_NONE;
    if (swreg_reg) begin
      wbe_next = sbyte_reg ? BE_LO : BE_WORD;
    end
    yrdata_next = yok_reg ? y_rdata_i : 16'h0000;
    yrv_next    = yrd_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xrdata_reg <= 16'h0000;
      xrv_reg    <= 1'b0;
      wbe_reg    <= BE_NONE;
      yrdata_reg <= 16'h0000;
      yrv_reg    <= 1'b0;
    end else if (ce_i) begin
      xrdata_reg <= xrdata_next;
      xrv_reg    <= xrv_next;
      wbe_reg    <= wbe_next;
      yrdata_reg <= yrdata_next;
      yrv_reg    <= yrv_next;
    end
  end

  // Outputs straight from flops
  assign pc_o            = pc_reg;
  assign prog_addr_o     = paddr_reg;
  assign prog_fault_o    = fault_reg;
  assign vector_region_o = vec_reg;
  assign ivt_hit_o       = ivt_reg;
  assign aivt_hit_o      = aivt_reg;
  assign vector_index_o  = vidx_reg;
  assign tbl_data_o      = tdata_reg;
  assign x_word_addr_o   = xwa_reg;
  assign x_rd_en_o       = xrd_reg;
  assign x_wr_be_o       = xbe_reg;
  assign x_wdata_o       = xwd_reg;
  assign addr_error_o    = err_reg;
  assign psv_sel_o       = psv_reg;
  assign x_ptr_next_o    = xptr_reg;
  assign x_rdata_o       = xrdata_reg;
  assign x_rvalid_o      = xrv_reg;
  assign wreg_be_o       = wbe_reg;
  assign y_word_addr_o   = ywa_reg;
  assign y_rd_en_o       = yrd_reg;
  assign y_ptr_next_o    = yptr_reg;
  assign y_rdata_o       = yrdata_reg;
  assign y_rvalid_o      = yrv_reg;

  // Checks
  property p_pc_even;
    @(posedge clk_i) disable iff (!rst_n_i)
    !pc_o[0];
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc odd");

  property p_pc_step;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && pc_step_i && !pc_load_i && !pc_dir_dn_i
    |=> pc_o == $past(pc_o) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step");

  property p_psv_fault;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && psv_fetch_i && !tbl_op_i && psv_page_i[PG_CFG_BIT]
    |=> prog_fault_o;
  endproperty
  a_psv_fault: assert property (p_psv_fault) else $error("no fault");

  property p_vec;
    @(posedge clk_i) disable iff (!rst_n_i)
    vector_region_o == (prog_addr_o < VECTOR_END);
  endproperty
  a_vec: assert property (p_vec) else $error("vector region");

  property p_tbl_upper;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && prog_addr_o[0] |=> tbl_data_o[15:8] == 8'h00;
  endproperty
  a_tbl_upper: assert property (p_tbl_upper) else $error("upper");

  property p_misalign;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && acc_valid_i && !acc_byte_i && x_ea[0]
    |=> addr_error_o && x_wr_be_o == BE_NONE;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misalign");

  property p_byte_be;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && acc_valid_i && acc_write_i && acc_byte_i && zone == ZN_RAM
    |=> x_wr_be_o == ($past(x_ea[0]) ? BE_HI : BE_LO);
  endproperty
  a_byte_be: assert property (p_byte_be) else $error("byte lane");

  property p_zero_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && acc_valid_i && !acc_write_i && x_ea > DATA_END) ##1 ce_i
    |=> x_rvalid_o && x_rdata_o == 16'h0000;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("not zero");

  property p_byte_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && acc_valid_i && !acc_write_i && acc_byte_i) ##1 ce_i
    |=> x_rdata_o[15:8] == 8'h00;
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("lane");

  property p_ptr_step;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && acc_valid_i && amode_i == AM_INDIRECT && acc_byte_i &&
    !x_dec_i && !mod_en_i && !brev_en_i
    |=> x_ptr_next_o == $past(x_ptr_i) + BYTE_STEP;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("ptr step");

  property p_dual;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && acc_valid_i && !acc_write_i && y_valid_i
    |=> x_rd_en_o && y_rd_en_o;
  endproperty
  a_dual: assert property (p_dual) else $error("dual fetch");
endmodule

// ### verif/msd_mem_model.sv
module msd_mem_model (
  input  wire logic [14:0] x_addr_i,
  input  wire logic        x_rd_i,
  input  wire logic [14:0] y_addr_i,
  input  wire logic        y_rd_i,
  input  wire logic [23:0] p_addr_i,
  output logic [15:0]      mem_rdata_o,
  output logic [15:0]      sfr_rdata_o,
  output logic             sfr_ack_o,
  output logic [15:0]      y_rdata_o,
  output logic [23:0]      p_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word content derived from the word address
  function automatic logic [15:0] pat(input logic [14:0] a);
    return {a[7:0] ^ 8'h5A, a[14:7]};
  endfunction
  // X word, inverted while no read is under way
  assign mem_rdata_o = x_rd_i ? pat(x_addr_i) : ~pat(x_addr_i);
  // Registers answer on every other 32-word group
  assign sfr_ack_o = x_rd_i && (x_addr_i < 15'h0400) && !x_addr_i[5];
  assign sfr_rdata_o = sfr_ack_o ? ~pat(x_addr_i) : pat(x_addr_i);
  // Y word on its own path
  assign y_rdata_o = y_rd_i ? pat(y_addr_i) : ~pat(y_addr_i);
  // Program word, 24 bits
  assign p_word_o = {p_addr_i[7:0] ^ 8'hC3, p_addr_i[15:0]};
endmodule

// ### verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import msd_pkg::*;
  logic clk_i, rst_n_i, ce_i, pc_step_i, pc_dir_dn_i, pc_load_i, tbl_op_i;
  logic psv_fetch_i, acc_valid_i, acc_write_i, acc_byte_i, x_dec_i, mod_en_i;
  logic brev_en_i, dst_wreg_i, sfr_ack_i, y_valid_i, y_dec_i;
  logic [22:0] pc_target_i, pc_o;
  logic [7:0]  table_page_register_i, psv_page_i;
  logic [23:0] prog_word_i, prog_addr_o;
  logic [15:0] tbl_offset_i, direct_addr_i, x_ptr_i, mod_start_i, mod_end_i;
  logic [15:0] brev_mod_i, wdata_i, mem_rdata_i, sfr_rdata_i, y_ptr_i;
  logic [15:0] y_rdata_i, tbl_data_o, x_wdata_o, x_ptr_next_o, x_rdata_o;
  logic [15:0] y_ptr_next_o, y_rdata_o;
  msd_amode_type amode_i;
  logic prog_fault_o, vector_region_o, ivt_hit_o, aivt_hit_o, x_rd_en_o;
  logic addr_error_o, psv_sel_o, x_rvalid_o, y_rd_en_o, y_rvalid_o;
  logic [6:0]  vector_index_o;
  logic [14:0] x_word_addr_o, y_word_addr_o;
  logic [1:0]  x_wr_be_o, wreg_be_o;
  logic [23:0] c_wa, c_be, c_wd, c_err, c_psv, c_ptr, c_rd, c_rdat, c_wreg;
  logic [23:0] c_ywa, c_yrd, c_yptr, c_yrdat, c_pa, c_flt, c_vec, c_td;
  logic [23:0] pw;
  logic [15:0] ev;
  logic        mod_on, dec_on;
  int          bad_count, samples_checked;

  msd_decoder i_dut (.*);
  msd_mem_model i_mem (
    .x_addr_i   (x_word_addr_o),
    .x_rd_i     (x_rd_en_o),
    .y_addr_i   (y_word_addr_o),
    .y_rd_i     (y_rd_en_o),
    .p_addr_i   (prog_addr_o),
    .mem_rdata_o(mem_rdata_i),
    .sfr_rdata_o(sfr_rdata_i),
    .sfr_ack_o  (sfr_ack_i),
    .y_rdata_o  (y_rdata_i),
    .p_word_o   (prog_word_i)
  );

  // Clock, 4 ns period
  always #2 clk_i = ~clk_i;

  // Expected data word for a word address
  function automatic logic [15:0] ew(input logic [14:0] a);
    return {a[7:0] ^ 8'h5A, a[14:7]};
  endfunction

  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string msg);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One PC operation, result one edge later
  task automatic pc_op(input logic s, input logic dn, input logic ld,
                       input logic [22:0] t, input logic [22:0] e);
    @(posedge clk_i);
    pc_step_i <= s;
    pc_dir_dn_i <= dn;
    pc_load_i <= ld;
    pc_target_i <= t;
    @(posedge clk_i);
    pc_step_i <= 1'b0;
    pc_load_i <= 1'b0;
    #1;
    chk({1'b0, pc_o}, {1'b0, e}, "pc");
  endtask

  // One program request; data two edges on
  task automatic prog(input logic tb, input logic ps, input logic [7:0] pg,
                      input logic [15:0] off);
    @(posedge clk_i);
    tbl_op_i <= tb;
    psv_fetch_i <= ps;
    table_page_register_i <= pg;
    psv_page_i <= pg;
    tbl_offset_i <= off;
    @(posedge clk_i);
    tbl_op_i <= 1'b0;
    psv_fetch_i <= 1'b0;
    #1;
    c_pa = prog_addr_o;
    c_flt = {23'h0, prog_fault_o};
    c_vec = {14'h0, vector_region_o, ivt_hit_o, aivt_hit_o, vector_index_o};
    pw = {prog_addr_o[7:0] ^ 8'hC3, prog_addr_o[15:0]};
    @(posedge clk_i);
    #1;
    c_td = {8'h0, tbl_data_o};
  endtask

  // One X access, optional Y fetch alongside
  task automatic xacc(input logic w, input logic b, input msd_amode_type m,
                      input logic [15:0] a, input logic [15:0] d,
                      input logic yv, input logic [15:0] yp);
    @(posedge clk_i);
    acc_valid_i <= 1'b1;
    acc_write_i <= w;
    acc_byte_i <= b;
    amode_i <= m;
    x_ptr_i <= a;
    direct_addr_i <= a;
    wdata_i <= d;
    x_dec_i <= dec_on;
    y_dec_i <= dec_on;
    mod_en_i <= mod_on;
    brev_en_i <= mod_on;
    y_valid_i <= yv;
    y_ptr_i <= yp;
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    y_valid_i <= 1'b0;
    #1;
    c_wa = {9'h0, x_word_addr_o};
    c_be = {22'h0, x_wr_be_o};
    c_wd = {8'h0, x_wdata_o};
    c_err = {23'h0, addr_error_o};
    c_psv = {23'h0, psv_sel_o};
    c_ptr = {8'h0, x_ptr_next_o};
    c_rd = {23'h0, x_rd_en_o};
    c_ywa = {9'h0, y_word_addr_o};
    c_yrd = {23'h0, y_rd_en_o};
    c_yptr = {8'h0, y_ptr_next_o};
    @(posedge clk_i);
    #1;
    c_rdat = {8'h0, x_rdata_o};
    c_wreg = {22'h0, wreg_be_o};
    c_yrdat = {8'h0, y_rdata_o};
  endtask

  // Reset state and program counter
  task automatic t_pc;
    chk({1'b0, pc_o}, 24'h0, "pc reset");
    chk({23'h0, vector_region_o}, 24'h1, "vector reset");
    pc_op(1'b1, 1'b0, 1'b0, 23'h0, 23'h000002);
    pc_op(1'b1, 1'b0, 1'b0, 23'h0, 23'h000004);
    pc_op(1'b1, 1'b1, 1'b0, 23'h0, 23'h000002);
    pc_op(1'b0, 1'b0, 1'b1, 23'h123457, 23'h123456);
    repeat (2) @(posedge clk_i);
    #1;
    chk(prog_addr_o, {1'b0, pc_o}, "pc address");
  endtask

  // Table access, page limit, halves, vectors
  task automatic t_prog;
    prog(1'b1, 1'b0, 8'h80, 16'h0001);
    chk(c_pa, 24'h800001, "tbl addr");
    chk(c_flt, 24'h0, "tbl cfg fault");
    chk(c_td, {16'h0, pw[23:16]}, "upper word");
    prog(1'b0, 1'b1, 8'h80, 16'h0000);
    chk(c_flt, 24'h1, "remap fault");
    prog(1'b1, 1'b0, 8'h7F, 16'hFFFE);
    chk(c_flt, 24'h0, "user top");
    chk(c_td, {8'h0, pw[15:0]}, "lower word");
    prog(1'b1, 1'b0, 8'h00, 16'h0006);
    chk(c_vec, {14'h0, 3'b110, 7'h03}, "ivt");
    prog(1'b1, 1'b0, 8'h00, 16'h0106);
    chk(c_vec, {14'h0, 3'b101, 7'h03}, "aivt");
    prog(1'b1, 1'b0, 8'h00, 16'h0002);
    chk(c_vec, {14'h0, 3'b100, 7'h01}, "reset target");
    prog(1'b1, 1'b0, 8'h00, 16'h0200);
    chk(c_vec, 24'h0, "past vectors");
  endtask

  // Byte lanes, pointer steps and post-modify
  task automatic t_bytes;
    ev = ew(15'h0400);
    xacc(1'b0, 1'b1, AM_INDIRECT, 16'h0801, 16'h0, 1'b0, 16'h0);
    chk(c_wa, 24'h000400, "word decode");
    chk(c_rdat, {16'h0, ev[15:8]}, "odd byte");
    chk(c_wreg, 24'h1, "byte load lane");
    chk(c_ptr, 24'h000802, "byte step");
    xacc(1'b0, 1'b1, AM_INDIRECT, 16'h0800, 16'h0, 1'b0, 16'h0);
    chk(c_rdat, {16'h0, ev[7:0]}, "even byte");
    chk(c_ptr, 24'h000801, "byte step");
    xacc(1'b0, 1'b0, AM_INDIRECT, 16'h0800, 16'h0, 1'b0, 16'h0);
    chk(c_rdat, {8'h0, ev}, "word read");
    chk(c_wreg, 24'h3, "word load lanes");
    chk(c_ptr, 24'h000802, "word step");
    dec_on = 1'b1;
    xacc(1'b0, 1'b0, AM_INDIRECT, 16'h0804, 16'h0, 1'b0, 16'h0);
    chk(c_ptr, 24'h000802, "word dec");
    dec_on = 1'b0;
    mod_on = 1'b1;
    xacc(1'b0, 1'b0, AM_INDIRECT, 16'h1002, 16'h0, 1'b0, 16'h0);
    chk(c_ptr, 24'h001000, "modulo wrap");
    xacc(1'b1, 1'b0, AM_INDIRECT, 16'h0008, 16'h0, 1'b0, 16'h0);
    chk(c_ptr, 24'h000004, "brev");
    mod_on = 1'b0;
    xacc(1'b1, 1'b1, AM_DIRECT, 16'h1235, 16'h00A7, 1'b0, 16'h0);
    chk(c_be, 24'h2, "odd byte strobe");
    chk(c_wd, 24'h00A7A7, "byte data");
    xacc(1'b1, 1'b1, AM_DIRECT, 16'h1234, 16'h00A7, 1'b0, 16'h0);
    chk(c_be, 24'h1, "even byte strobe");
  endtask

  // Misalign, zero reads, registers, modes
  task automatic t_space;
    xacc(1'b1, 1'b0, AM_DIRECT, 16'h1235, 16'hBEEF, 1'b0, 16'h0);
    chk(c_be, 24'h0, "odd write blocked");
    chk(c_err, 24'h1, "odd write trap");
    xacc(1'b0, 1'b0, AM_DIRECT, 16'h1001, 16'h0, 1'b0, 16'h0);
    chk(c_rd, 24'h1, "odd read done");
    chk(c_err, 24'h1, "odd read trap");
    xacc(1'b1, 1'b0, AM_DIRECT, 16'h1234, 16'hBEEF, 1'b0, 16'h0);
    chk(c_be, 24'h3, "word strobe");
    chk(c_wd, 24'h00BEEF, "word data");
    chk(c_err, 24'h0, "aligned no trap");
    xacc(1'b0, 1'b0, AM_DIRECT, 16'h4000, 16'h0, 1'b0, 16'h0);
    chk(c_rdat, 24'h0, "beyond memory");
    xacc(1'b0, 1'b0, AM_DIRECT, 16'h8000, 16'h0, 1'b0, 16'h0);
    chk(c_psv, 24'h1, "window select");
    chk(c_rdat, 24'h0, "window zero");
    xacc(1'b0, 1'b0, AM_DIRECT, 16'h0040, 16'h0, 1'b0, 16'h0);
    chk(c_rdat, 24'h0, "unused register");
    ev = ~ew(15'h0008);
    xacc(1'b0, 1'b0, AM_DIRECT, 16'h0010, 16'h0, 1'b0, 16'h0);
    chk(c_rdat, {8'h0, ev}, "register read");
    xacc(1'b0, 1'b0, AM_NEAR, 16'hFFFE, 16'h0, 1'b0, 16'h0);
    chk(c_wa, 24'h000FFF, "near field");
    ev = ew(15'h1FFF);
    xacc(1'b0, 1'b0, AM_DIRECT, 16'h3FFE, 16'h0, 1'b0, 16'h0);
    chk(c_wa, 24'h001FFF, "direct field");
    chk(c_rdat, {8'h0, ev}, "direct data");
  endtask

  // Concurrent X and Y fetch
  task automatic t_dual;
    ev = ew(15'h0601);
    xacc(1'b0, 1'b0, AM_INDIRECT, 16'h0800, 16'h0, 1'b1, 16'h0C02);
    chk(c_ywa, 24'h000601, "y addr");
    chk(c_yrd, 24'h1, "y read");
    chk(c_yrdat, {8'h0, ev}, "y data");
    chk(c_yptr, 24'h000C04, "y step");
    chk({22'h0, x_rvalid_o, y_rvalid_o}, 24'h3, "rvalid");
    ev = ew(15'h0400);
    chk(c_rdat, {8'h0, ev}, "x prefetch");
    xacc(1'b0, 1'b0, AM_INDIRECT, 16'h0800, 16'h0, 1'b1, 16'h0A00);
    chk(c_yrdat, 24'h0, "y below boundary");
    xacc(1'b0, 1'b0, AM_INDIRECT, 16'h0800, 16'h0, 1'b1, 16'h0C03);
    chk(c_err, 24'h1, "y odd trap");
  endtask

  // Main sequence
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    {pc_step_i, pc_dir_dn_i, pc_load_i, tbl_op_i, psv_fetch_i} = '0;
    {acc_valid_i, acc_write_i, acc_byte_i, x_dec_i, mod_en_i} = '0;
    {brev_en_i, y_valid_i, y_dec_i, mod_on, dec_on} = '0;
    dst_wreg_i = 1'b1;
    {pc_target_i, table_page_register_i, psv_page_i, tbl_offset_i} = '0;
    {direct_addr_i, x_ptr_i, wdata_i, y_ptr_i} = '0;
    mod_start_i = 16'h1000;
    mod_end_i = 16'h1003;
    brev_mod_i = 16'h0008;
    amode_i = AM_DIRECT;
    bad_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    t_pc();
    t_prog();
    t_bytes();
    t_space();
    t_dual();
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule
